// >>> tcu_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module tcu_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus
  input wire tcu_pkg::tcu_axi_req_type axi_req,
  output tcu_pkg::tcu_axi_rsp_type axi_rsp,
  // Capture pins, asynchronous
  input wire logic capture_input_zero,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic capture_input_three,
  // Output port
  output logic [7:0] port_out,
  // Interrupt requests
  output logic [8:0] timer_irq_req,
  output logic [8:0] timer_irq_high
);
  import tcu_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a[ADDR_W-1:2] == {2'b00, idx};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  tcu_phase_type phase_q;
  logic [7:0] edge_sel_q, rst_tgl_en_q, ctrl_q, prio_q, flags_q, flags_view_q, port_q;
  logic [7:0] hw_mask_q, sw_data_q, port_hw, hw_mask, flag_set, flag_clr, rd_byte;
  logic [5:0] set_en_q, set_m, clr_m;
  logic [1:0] tg_q, tog, primed_q, bresp_q, rresp_q;
  logic [15:0] timer_q;
  logic [15:0] cap_q [4];
  logic [15:0] cmp_q [3];
  logic [3:0] pin_s1_q, pin_s2_q, samp_q, prev_q, cap_hit, cap_set, wstrb_q;
  logic [2:0] mpend_q, match_v;
  logic inc_q, byte_ovf_q, sw_pend_q, sw_now, run, ovf_byte, ovf_word;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q, wr_en, wr_b0, rd_ok, ar_fire;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_word;

  // Machine cycle sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= PH_S1;
    end else begin
      case (phase_q)
        PH_S1: phase_q <= PH_S2;
        PH_S2: phase_q <= PH_S3;
        PH_S3: phase_q <= PH_S4;
        PH_S4: phase_q <= PH_S5;
        PH_S5: phase_q <= PH_S6;
        PH_S6: phase_q <= PH_S1;
        default: phase_q <= PH_S1;
      endcase
    end
  end

  // Bus write channel; one write in flight, address and data in either order
  assign wr_en = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_b0 = wr_en & wstrb_q[0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end else if (wr_en) begin
        aw_held_q <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held_q <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end else if (wr_en) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= rd_ok_w(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  function automatic logic rd_ok_w(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = hit(a, IDX_EDGE_SEL) | hit(a, IDX_RST_TGL_EN) | hit(a, IDX_SET_EN) |
         hit(a, IDX_FLAGS) | hit(a, IDX_CTRL) | hit(a, IDX_PRIO) |
         hit(a, IDX_TIMER) | hit(a, IDX_PORT);
    for (int k = 0; k < 4; k++) begin
      ok = ok | hit(a, IDX_CAP0 + 8'(k));
    end
    for (int k = 0; k < 3; k++) begin
      ok = ok | hit(a, IDX_CMP0 + 8'(k));
    end
    return ok;
  endfunction

  // Control registers written by software
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_sel_q <= RST_BYTE;
      rst_tgl_en_q <= RST_BYTE;
      set_en_q <= RST_BYTE[5:0];
      ctrl_q <= RST_BYTE;
      prio_q <= RST_BYTE;
    end else if (wr_b0) begin
      if (hit(awaddr_q, IDX_EDGE_SEL)) edge_sel_q <= wdata_q[7:0];
      if (hit(awaddr_q, IDX_RST_TGL_EN)) rst_tgl_en_q <= wdata_q[7:0];
      if (hit(awaddr_q, IDX_SET_EN)) set_en_q <= wdata_q[5:0];
      // Byte overflow flag lives apart from the writable bits
      if (hit(awaddr_q, IDX_CTRL)) ctrl_q <= wdata_q[7:0] & ~(8'h01 << CTRL_BYTE_OVF_BIT);
      if (hit(awaddr_q, IDX_PRIO)) prio_q <= wdata_q[7:0];
    end
  end

  // Compare registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < 3; k++) begin
        cmp_q[k] <= RST_WORD;
      end
    end else if (wr_en) begin
      for (int k = 0; k < 3; k++) begin
        if (hit(awaddr_q, IDX_CMP0 + 8'(k))) begin
          cmp_q[k] <= merge16(cmp_q[k], wdata_q, wstrb_q);
        end
      end
    end
  end

  // Shared timer; prescaler left out, so one count per machine cycle
  assign run = ctrl_q[CTRL_RUN_BIT];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_q <= RST_WORD;
    end else if (phase_q == PH_S6 && run) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // Capture pins: two-flop synchroniser, then the S1 sample
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      samp_q <= '0;
      prev_q <= '0;
      primed_q <= '0;
    end else begin
      pin_s1_q <= {capture_input_three, capture_input_two, capture_input_one,
                   capture_input_zero};
      pin_s2_q <= pin_s1_q;
      if (phase_q == PH_S1) begin
        samp_q <= pin_s2_q;
        prev_q <= primed_q[1] ? samp_q : pin_s2_q;
        // Early samples predate the synchroniser, so history starts from the pin
        primed_q <= {primed_q[0], 1'b1};
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cap_hit[i] = primed_q[1] & ((samp_q[i] & ~prev_q[i] & edge_sel_q[2*i]) |
                                  (~samp_q[i] & prev_q[i] & edge_sel_q[2*i+1]));
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        cap_q[i] <= RST_WORD;
      end
    end else if (phase_q == PH_S6) begin
      for (int i = 0; i < 4; i++) begin
        if (cap_hit[i]) begin
          cap_q[i] <= timer_q;
        end
      end
    end
  end

  // Channels 0,1 flag in S4, channels 2,3 in S6
  assign cap_set[1:0] = (phase_q == PH_S3) ? cap_hit[1:0] : 2'b00;
  assign cap_set[3:2] = (phase_q == PH_S5) ? cap_hit[3:2] : 2'b00;

  // Compare: the count after an increment is checked in the next cycle
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      match_v[k] = cmp_q[k] == timer_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inc_q <= 1'b0;
      mpend_q <= '0;
    end else if (phase_q == PH_S6) begin
      inc_q <= run;
      mpend_q <= inc_q ? match_v : 3'b000;
    end
  end

  // Port update from matches, applied at end of S4 of the next cycle
  assign set_m = mpend_q[0] ? set_en_q : 6'h00;
  assign clr_m = mpend_q[1] ? rst_tgl_en_q[5:0] : 6'h00;
  assign tog = mpend_q[2] ? rst_tgl_en_q[7:6] : 2'b00;
  assign port_hw[5:0] = (port_q[5:0] | set_m) & ~clr_m;
  assign port_hw[6] = tog[0] ? tg_q[0] : port_q[6];
  assign port_hw[7] = tog[1] ? tg_q[1] : port_q[7];
  assign hw_mask = {tog, set_m | clr_m};
  assign sw_now = sw_pend_q | (wr_b0 && hit(awaddr_q, IDX_PORT));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_pend_q <= 1'b0;
      sw_data_q <= RST_PORT;
    end else if (phase_q == PH_S6) begin
      sw_pend_q <= 1'b0;
    end else if (wr_b0 && hit(awaddr_q, IDX_PORT)) begin
      sw_pend_q <= 1'b1;
      sw_data_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_q <= RST_PORT;
      tg_q <= RST_TOGGLE;
      hw_mask_q <= '0;
    end else if (phase_q == PH_S4) begin
      port_q <= port_hw;
      tg_q <= tg_q ^ tog;
      hw_mask_q <= hw_mask;
    end else if (phase_q == PH_S6) begin
      hw_mask_q <= '0;
      if (sw_now) begin
        // Bits a match touched this cycle keep the hardware value
        port_q <= (port_q & hw_mask_q) |
                  ((wr_b0 && hit(awaddr_q, IDX_PORT) ? wdata_q[7:0] : sw_data_q) & ~hw_mask_q);
      end
    end
  end

  assign port_out = port_q;

  // Flags: set wins over a clear in the same cycle
  assign ovf_byte = phase_q == PH_S5 && run && timer_q[7:0] == 8'hFF;
  assign ovf_word = phase_q == PH_S5 && run && timer_q == 16'hFFFF;
  assign flag_set = {ovf_word, (phase_q == PH_S5) ? mpend_q : 3'b000, cap_set};
  assign flag_clr = (wr_b0 && hit(awaddr_q, IDX_FLAGS)) ? wdata_q[7:0] : 8'h00;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= RST_BYTE;
      byte_ovf_q <= 1'b0;
      flags_view_q <= RST_BYTE;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      byte_ovf_q <= (byte_ovf_q & ~(wr_b0 && hit(awaddr_q, IDX_CTRL) &&
                     wdata_q[CTRL_BYTE_OVF_BIT])) | ovf_byte;
      if (phase_q == PH_S5) begin
        flags_view_q <= flags_q;
      end
    end
  end

  // Interrupt scan, two sources per state in S1 to S4, flag 3 alone in S5
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_irq_req <= '0;
    end else begin
      case (phase_q)
        PH_S1: begin
          timer_irq_req[7] <= flags_q[FLAG_WORD_OVF_BIT] & ctrl_q[CTRL_WORD_IRQ_BIT];
          timer_irq_req[8] <= byte_ovf_q & ctrl_q[CTRL_BYTE_IRQ_BIT];
        end
        PH_S2: begin
          timer_irq_req[0] <= flags_q[0];
          timer_irq_req[4] <= flags_q[4];
        end
        PH_S3: begin
          timer_irq_req[1] <= flags_q[1];
          timer_irq_req[5] <= flags_q[5];
        end
        PH_S4: begin
          timer_irq_req[2] <= flags_q[2];
          timer_irq_req[6] <= flags_q[6];
        end
        PH_S5: begin
          timer_irq_req[3] <= flags_q[3];
        end
        default: timer_irq_req <= timer_irq_req;
      endcase
    end
  end

  // Both overflows share one priority bit
  assign timer_irq_high = timer_irq_req & {prio_q[7], prio_q};

  // Read channel
  always_comb begin
    rd_word = '0;
    rd_byte = '0;
    rd_ok = rd_ok_w(axi_req.araddr);
    if (hit(axi_req.araddr, IDX_EDGE_SEL)) rd_byte = edge_sel_q;
    if (hit(axi_req.araddr, IDX_RST_TGL_EN)) rd_byte = rst_tgl_en_q;
    if (hit(axi_req.araddr, IDX_SET_EN)) rd_byte = {tg_q[1], tg_q[0], set_en_q};
    if (hit(axi_req.araddr, IDX_FLAGS)) rd_byte = flags_view_q;
    if (hit(axi_req.araddr, IDX_CTRL)) rd_byte = ctrl_q | {3'b000, byte_ovf_q, 4'h0};
    if (hit(axi_req.araddr, IDX_PRIO)) rd_byte = prio_q;
    if (hit(axi_req.araddr, IDX_PORT)) rd_byte = port_q;
    rd_word[7:0] = rd_byte;
    if (hit(axi_req.araddr, IDX_TIMER)) rd_word[15:0] = timer_q;
    for (int k = 0; k < 4; k++) begin
      if (hit(axi_req.araddr, IDX_CAP0 + 8'(k))) rd_word[15:0] = cap_q[k];
    end
    for (int k = 0; k < 3; k++) begin
      if (hit(axi_req.araddr, IDX_CMP0 + 8'(k))) rd_word[15:0] = cmp_q[k];
    end
  end

  assign ar_fire = axi_req.arvalid & ~rvalid_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp.awready = ~aw_held_q & ~bvalid_q;
    axi_rsp.wready = ~w_held_q & ~bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.arready = ~rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
    axi_rsp.rvalid = rvalid_q;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence match0_seen;
    phase_q == PH_S6 && inc_q && match_v[0];
  endsequence

  cap_load_a: assert property (phase_q == PH_S6 && cap_hit[0] |=> cap_q[0] == $past(timer_q))
    else $error("capture zero did not load timer");
  flag_early_a: assert property ($rose(flags_q[0]) |-> phase_q == PH_S4)
    else $error("capture flag zero set outside S4");
  flag_late_a: assert property ($rose(flags_q[2]) |-> phase_q == PH_S6)
    else $error("capture flag two set outside S6");
  cmp_flag_a: assert property (match0_seen |-> ##6 flags_q[FLAG_CMP0_BIT])
    else $error("compare zero flag not set after match");
  clear_wins_a: assert property (phase_q == PH_S4 && mpend_q[0] && mpend_q[1] && set_en_q[0]
                                 && rst_tgl_en_q[0] |=> !port_q[0])
    else $error("set and clear together did not clear");
  toggle_step_a: assert property (phase_q == PH_S4 && tog[0] |=>
                                  port_q[6] == $past(tg_q[0]) && tg_q[0] != $past(tg_q[0]))
    else $error("toggle bit six wrong");
  no_select_a: assert property ($rose(flags_q[1]) |-> $past(edge_sel_q[3:2], 2) != 2'b00)
    else $error("capture flag without edge select");
  pin_phase_a: assert property (port_q != $past(port_q) |-> phase_q == PH_S5 || phase_q == PH_S1)
    else $error("port changed in wrong phase");
  timer_step_a: assert property (phase_q == PH_S6 && run |=> timer_q == $past(timer_q) + 16'h0001)
    else $error("timer did not count");

endmodule

// >>> tcu_pkg.sv
package tcu_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EDGE_SEL = 8'hEB;
  localparam logic [7:0] IDX_RST_TGL_EN = 8'hEF;
  localparam logic [7:0] IDX_SET_EN = 8'hEE;
  localparam logic [7:0] IDX_FLAGS = 8'hC8;
  localparam logic [7:0] IDX_CTRL = 8'hEA;
  localparam logic [7:0] IDX_PRIO = 8'hF8;
  localparam logic [7:0] IDX_CAP0 = 8'hD0;
  localparam logic [7:0] IDX_CMP0 = 8'hD4;
  localparam logic [7:0] IDX_TIMER = 8'hD7;
  localparam logic [7:0] IDX_PORT = 8'hD8;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_BYTE_OVF_BIT = 4;
  localparam int CTRL_BYTE_IRQ_BIT = 6;
  localparam int CTRL_WORD_IRQ_BIT = 7;
  localparam int FLAG_CMP0_BIT = 4;
  localparam int FLAG_WORD_OVF_BIT = 7;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RST_TOGGLE = 2'b11;
  localparam logic [7:0] RST_PORT = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Machine cycle states, one core clock each
  typedef enum logic [5:0] {
    PH_S1 = 6'b00_0001,
    PH_S2 = 6'b00_0010,
    PH_S3 = 6'b00_0100,
    PH_S4 = 6'b00_1000,
    PH_S5 = 6'b01_0000,
    PH_S6 = 6'b10_0000
  } tcu_phase_type;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } tcu_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tcu_axi_rsp_type;

endpackage

// >>> tcu_pins_model.sv
`timescale 1ns/100ps
module tcu_pins_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Port pins seen by the load
  input wire logic [7:0] port_out,
  // Event pins towards the capture inputs
  output logic [3:0] event_pins
);
  int unsigned clk_count;
  int unsigned change_stamp;
  logic [7:0] port_seen;

  // Channel one idles high so its first move is a falling edge
  initial event_pins = 4'b0010;

  // Pins move only just after a clock edge, like a slow external source
  task automatic drive_pin(input int ch, input logic level);
    @(posedge core_clk);
    event_pins[ch] <= level;
  endtask

  // Time stamp of the last pin change; only differences are meaningful
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_count <= 0;
      change_stamp <= 0;
      port_seen <= 8'h00;
    end else begin
      clk_count <= clk_count + 1;
      port_seen <= port_out;
      if (port_out !== port_seen)
        change_stamp <= clk_count;
    end
  end
endmodule

// >>> timer_capture_compare_unit_test.sv
`timescale 1ns/100ps
module timer_capture_compare_unit_test;
  import tcu_pkg::*;
  typedef struct {
    logic [7:0] idx;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic [1:0] resp;
  } tcu_row_type;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  tcu_axi_req_type req = '0;
  tcu_axi_rsp_type rsp;
  logic [3:0] event_pins;
  logic [7:0] port_out;
  logic [8:0] irq_req;
  logic [8:0] irq_high;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [15:0] t_stop;
  int unsigned stamp0;
  // Reset reads first, then write and read back
  tcu_row_type rows[19] = '{
    '{IDX_EDGE_SEL, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_SET_EN, 1'b0, 32'h0000_0000, 32'h0000_00c0, RESP_OKAY},
    '{IDX_RST_TGL_EN, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_FLAGS, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_PRIO, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_CAP0, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_CMP0, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_TIMER, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{IDX_PORT, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{8'h00, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR},
    '{IDX_EDGE_SEL, 1'b1, 32'h0000_00a5, 32'h0000_00a5, RESP_OKAY},
    '{IDX_SET_EN, 1'b1, 32'h0000_003f, 32'h0000_00ff, RESP_OKAY},
    '{IDX_RST_TGL_EN, 1'b1, 32'h0000_005a, 32'h0000_005a, RESP_OKAY},
    '{IDX_PRIO, 1'b1, 32'h0000_0096, 32'h0000_0096, RESP_OKAY},
    '{8'hd5, 1'b1, 32'h0000_beef, 32'h0000_beef, RESP_OKAY},
    '{IDX_TIMER, 1'b1, 32'h0000_1234, 32'h0000_0000, RESP_OKAY},
    '{8'hd1, 1'b1, 32'h0000_4321, 32'h0000_0000, RESP_OKAY},
    '{8'h00, 1'b1, 32'h0000_0001, 32'h0000_0000, RESP_SLVERR}
  };

  tcu_top u_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .axi_req(req),
    .axi_rsp(rsp),
    .capture_input_zero(event_pins[0]),
    .capture_input_one(event_pins[1]),
    .capture_input_two(event_pins[2]),
    .capture_input_three(event_pins[3]),
    .port_out(port_out),
    .timer_irq_req(irq_req),
    .timer_irq_high(irq_high)
  );

  tcu_pins_model u_pins (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .port_out(port_out),
    .event_pins(event_pins)
  );

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    n_errors++;
    $display("[FAIL] %s expected answer seen none", what);
    report_and_stop();
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is looked at mid-cycle, where it equals what the next edge samples
  task automatic bus_write(input logic [7:0] idx, input logic [31:0] data, output logic [1:0] br);
    int n;
    logic a_go;
    logic w_go;
    logic b_go;
    @(posedge core_clk);
    req.awaddr <= {2'b00, idx, 2'b00};
    req.awvalid <= 1'b1;
    req.wdata <= data;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    br = 2'b11;
    for (n = 0; n < 64; n++) begin
      @(negedge core_clk);
      a_go = req.awvalid & rsp.awready;
      w_go = req.wvalid & rsp.wready;
      b_go = rsp.bvalid;
      br = rsp.bresp;
      @(posedge core_clk);
      if (a_go)
        req.awvalid <= 1'b0;
      if (w_go)
        req.wvalid <= 1'b0;
      if (b_go) begin
        req.bready <= 1'b0;
        break;
      end
    end
    if (n == 64)
      hang("write response");
  endtask

  task automatic bus_read(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] rr);
    int n;
    logic a_go;
    logic r_go;
    @(posedge core_clk);
    req.araddr <= {2'b00, idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge core_clk);
      a_go = req.arvalid & rsp.arready;
      r_go = rsp.rvalid;
      data = rsp.rdata;
      rr = rsp.rresp;
      @(posedge core_clk);
      if (a_go)
        req.arvalid <= 1'b0;
      if (r_go) begin
        req.rready <= 1'b0;
        break;
      end
    end
    if (n == 64)
      hang("read data");
  endtask

  // Flag reads lag by up to one machine cycle, so poll a bounded number of times
  task automatic poll(input string what, input logic [7:0] idx, input logic [31:0] exp);
    int n;
    for (n = 0; n < 40; n++) begin
      bus_read(idx, rd, resp);
      if (rd === exp)
        break;
    end
    check(what, exp, rd);
  endtask

  task automatic wait_port(input logic [7:0] exp);
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge core_clk);
      if (port_out === exp)
        break;
    end
    check("port_out", 32'(exp), 32'(port_out));
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        bus_write(rows[i].idx, rows[i].wdata, resp);
        check("write resp", 32'(rows[i].resp), 32'(resp));
      end
      bus_read(rows[i].idx, rd, resp);
      check("reg data", rows[i].exp, rd);
      check("read resp", 32'(rows[i].resp), 32'(resp));
    end
    // Compare run: set, clear 0-3, toggle 6 and 7
    bus_write(IDX_CMP0, 32'h0000_0003, resp);
    bus_write(8'hd5, 32'h0000_0005, resp);
    bus_write(8'hd6, 32'h0000_0009, resp);
    bus_write(IDX_SET_EN, 32'h0000_003f, resp);
    bus_write(IDX_RST_TGL_EN, 32'h0000_00cf, resp);
    bus_write(IDX_CTRL, 32'h0000_0001, resp);
    wait_port(8'h3f);
    repeat (2) @(posedge core_clk);
    stamp0 = u_pins.change_stamp;
    wait_port(8'h30);
    repeat (2) @(posedge core_clk);
    check("match spacing", 32'd12, u_pins.change_stamp - stamp0);
    wait_port(8'hf0);
    poll("toggle state", IDX_SET_EN, 32'h0000_003f);
    bus_write(8'hd6, 32'h0000_0010, resp);
    wait_port(8'h30);
    poll("toggle state", IDX_SET_EN, 32'h0000_00ff);
    poll("flags", IDX_FLAGS, 32'h0000_0070);
    bus_write(IDX_CTRL, 32'h0000_0000, resp);
    bus_read(IDX_TIMER, rd, resp);
    t_stop = rd[15:0];
    check("timer range", 32'd1, 32'(t_stop >= 16 && t_stop < 40));
    // Capture on a frozen timer: ch0 rise, ch1 fall, ch2 both, ch3 off
    bus_write(IDX_FLAGS, 32'h0000_00ff, resp);
    bus_write(IDX_EDGE_SEL, 32'h0000_0039, resp);
    u_pins.drive_pin(0, 1'b1);
    u_pins.drive_pin(1, 1'b0);
    u_pins.drive_pin(2, 1'b1);
    u_pins.drive_pin(3, 1'b1);
    poll("flags", IDX_FLAGS, 32'h0000_0007);
    for (int i = 0; i < 4; i++) begin
      bus_read(IDX_CAP0 + 8'(i), rd, resp);
      check("capture", (i < 3) ? 32'(t_stop) : 32'h0000_0000, rd);
    end
    check("irq req", 32'h0000_0007, 32'(irq_req));
    bus_write(IDX_PRIO, 32'h0000_0001, resp);
    check("irq high", 32'h0000_0001, 32'(irq_high));
    bus_write(IDX_FLAGS, 32'h0000_0004, resp);
    poll("flags", IDX_FLAGS, 32'h0000_0003);
    u_pins.drive_pin(2, 1'b0);
    poll("flags", IDX_FLAGS, 32'h0000_0007);
    // Second reset in mid-run, then set and clear of one bit together
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus_read(IDX_CMP0, rd, resp);
    check("compare after reset", 32'h0000_0000, rd);
    bus_write(IDX_CMP0, 32'h0000_0002, resp);
    bus_write(8'hd5, 32'h0000_0002, resp);
    bus_write(IDX_SET_EN, 32'h0000_0003, resp);
    bus_write(IDX_RST_TGL_EN, 32'h0000_0001, resp);
    bus_write(IDX_CTRL, 32'h0000_0001, resp);
    wait_port(8'h02);
    bus_write(IDX_PORT, 32'h0000_0081, resp);
    wait_port(8'h81);
    // Byte overflow: flag in control bit 4, request on bit 8, cleared by writing one
    bus_write(IDX_CTRL, 32'h0000_0041, resp);
    for (int n = 0; n < 2000 && irq_req[8] !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    check("byte irq", 32'd1, 32'(irq_req[8]));
    bus_read(IDX_CTRL, rd, resp);
    check("byte flag", 32'h0000_0051, rd);
    bus_write(IDX_CTRL, 32'h0000_0011, resp);
    bus_read(IDX_CTRL, rd, resp);
    check("byte flag clear", 32'h0000_0001, rd);
    report_and_stop();
  end
endmodule
